/* rtl/cfo_pkg.sv */
package cfo_pkg;

    localparam int CFO_NUM_OUTPUTS = 18;

    // Address byte with write direction: 7-bit address 1101001, then 0
    localparam logic [7:0] CFO_DEV_ADDR_BYTE = 8'hD2;

    // Byte positions within one transfer
    localparam logic [2:0] CFO_IDX_ADDR = 3'h0;
    localparam logic [2:0] CFO_IDX_CMD = 3'h1;
    localparam logic [2:0] CFO_IDX_COUNT = 3'h2;
    localparam logic [2:0] CFO_IDX_CFG_LOW = 3'h3;
    localparam logic [2:0] CFO_IDX_CFG_MID = 3'h4;
    localparam logic [2:0] CFO_IDX_CFG_HIGH = 3'h5;
    localparam logic [2:0] CFO_IDX_EXTRA = 3'h6;

    // Bit count at which the ninth (acknowledge) clock begins
    localparam logic [3:0] CFO_BITS_PER_BYTE = 4'h8;

    // Used field of the high enable byte
    localparam int CFO_HIGH_MSB = 7;
    localparam int CFO_HIGH_LSB = 6;

    // Power-up enable values: everything on
    localparam logic [7:0] CFO_RST_EN_LOW = 8'hFF;
    localparam logic [7:0] CFO_RST_EN_MID = 8'hFF;
    localparam logic [1:0] CFO_RST_EN_HIGH = 2'h3;

    // Host link clock: period made by dividing the system clock
    localparam int CFO_CLK_PERIOD_NS = 20;
    localparam int CFO_LINK_PERIOD_NS = 160;
    localparam int CFO_QTR_CYC_CALC = CFO_LINK_PERIOD_NS / (4 * CFO_CLK_PERIOD_NS);
    localparam int CFO_QTR_CYC = (CFO_QTR_CYC_CALC < 1) ? 1 : CFO_QTR_CYC_CALC;

    typedef enum logic [1:0] {
        CFO_DEV_IDLE = 2'b00,
        CFO_DEV_RECV = 2'b01,
        CFO_DEV_ACK = 2'b10,
        CFO_DEV_SKIP = 2'b11
    } cfo_dev_state_t;

    typedef enum logic [1:0] {
        CFO_HOST_IDLE = 2'b00,
        CFO_HOST_START = 2'b01,
        CFO_HOST_BIT = 2'b10,
        CFO_HOST_STOP = 2'b11
    } cfo_host_state_t;

endpackage

/* rtl/cfo_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface cfo_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // Open-drain lines with pull-ups: low whenever any enabled driver pulls low
    assign scl = !(scl_host_oe && !scl_host_o);
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

    modport device (
        input scl,
        input sda,
        output sda_dev_o,
        output sda_dev_oe
    );

    modport host (
        input scl,
        input sda,
        output scl_host_o,
        output scl_host_oe,
        output sda_host_o,
        output sda_host_oe
    );
endinterface

`default_nettype wire

/* rtl/cfo_device.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - All outputs enabled and following after reset
// - Float pin low tristates all, high drives
// - Driven outputs are non-inverted buffer input copies
// - Answer only address byte D2 hexadecimal
// - Receive only; no read data, no subaddress
// - Host sends all preceding bytes to reach one
// - Eight bits MSB first, receiver acknowledges
// - Data changes only while clock low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Host opens with start, closes with stop
// - Direction bit high reads, low writes
// - Acknowledge ninth pulse, accept bytes until start/stop
// - Command and count bytes acknowledged, then ignored
// - First byte bit n enables output n
// - Second byte bit n enables output 8+n
// - Third byte bits 7,6 enable 17,16 only
// - Disabled output held low, not switching
module cfo_device
    import cfo_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    cfo_if.device bus,
    input wire logic i_buf_in,
    input wire logic i_float_n,
    output logic [CFO_NUM_OUTPUTS-1:0] o_clk_out,
    output logic [CFO_NUM_OUTPUTS-1:0] o_clk_oe,
    output logic [CFO_NUM_OUTPUTS-1:0] o_enables
);

    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    logic buf_s1;
    logic buf_s2;
    logic float_s1;
    logic float_s2;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic addr_match;
    logic ack_end;

    cfo_dev_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [2:0] byte_idx;
    logic ack_drive;

    logic [7:0] en_low;
    logic [7:0] en_mid;
    logic [1:0] en_high;
    logic [CFO_NUM_OUTPUTS-1:0] en_all;

    // Pins from outside pass two flops; the second stage and its delayed copy feed logic
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_q <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s1 <= bus.scl;
            scl_s2 <= scl_s1;
            scl_q <= scl_s2;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
            sda_q <= sda_s2;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            buf_s1 <= 1'b0;
            buf_s2 <= 1'b0;
            float_s1 <= 1'b1;
            float_s2 <= 1'b1;
        end else begin
            buf_s1 <= i_buf_in;
            buf_s2 <= buf_s1;
            float_s1 <= i_float_n;
            float_s2 <= float_s1;
        end
    end

    assign scl_rise = scl_s2 && !scl_q;
    assign scl_fall = !scl_s2 && scl_q;
    // Data edges count as conditions only with the clock high on both samples
    assign start_det = scl_s2 && scl_q && sda_q && !sda_s2;
    assign stop_det = scl_s2 && scl_q && !sda_q && sda_s2;

    assign byte_done = (state == CFO_DEV_RECV) && scl_fall && (bit_cnt == CFO_BITS_PER_BYTE);
    // A read request carries a set direction bit and so never matches
    assign addr_match = (shift == CFO_DEV_ADDR_BYTE);
    assign ack_end = (state == CFO_DEV_ACK) && scl_fall;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= CFO_DEV_IDLE;
        end else if (start_det) begin
            state <= CFO_DEV_RECV;
        end else if (stop_det) begin
            state <= CFO_DEV_IDLE;
        end else begin
            unique case (state)
                CFO_DEV_IDLE: begin
                    state <= CFO_DEV_IDLE;
                end
                CFO_DEV_RECV: begin
                    if (byte_done) begin
                        if (byte_idx == CFO_IDX_ADDR && !addr_match) begin
                            state <= CFO_DEV_SKIP;
                        end else begin
                            state <= CFO_DEV_ACK;
                        end
                    end
                end
                CFO_DEV_ACK: begin
                    if (scl_fall) begin
                        state <= CFO_DEV_RECV;
                    end
                end
                CFO_DEV_SKIP: begin
                    state <= CFO_DEV_SKIP;
                end
            endcase
        end
    end

    // Data is taken on the clock rise, when the line is settled
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bit_cnt <= 4'h0;
            shift <= 8'h00;
        end else if (start_det) begin
            bit_cnt <= 4'h0;
        end else if (state == CFO_DEV_RECV && scl_rise && bit_cnt != CFO_BITS_PER_BYTE) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift <= {shift[6:0], sda_s2};
        end else if (ack_end) begin
            bit_cnt <= 4'h0;
        end
    end

    // Bytes past the third enable byte are acknowledged and dropped
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            byte_idx <= CFO_IDX_ADDR;
        end else if (start_det) begin
            byte_idx <= CFO_IDX_ADDR;
        end else if (ack_end && byte_idx != CFO_IDX_EXTRA) begin
            byte_idx <= byte_idx + 3'h1;
        end
    end

    // Pull data low from the fall after bit eight to the fall after the ninth pulse
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_drive <= 1'b0;
        end else if (start_det || stop_det || ack_end) begin
            ack_drive <= 1'b0;
        end else if (byte_done && (byte_idx != CFO_IDX_ADDR || addr_match)) begin
            ack_drive <= 1'b1;
        end
    end

    // Open-drain: the device only ever pulls low, never drives high
    assign bus.sda_dev_o = 1'b0;
    assign bus.sda_dev_oe = ack_drive;

    // A byte takes effect once its acknowledge is complete; others keep their value
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_low <= CFO_RST_EN_LOW;
            en_mid <= CFO_RST_EN_MID;
            en_high <= CFO_RST_EN_HIGH;
        end else if (ack_end) begin
            unique case (byte_idx)
                CFO_IDX_CFG_LOW: begin
                    en_low <= shift;
                end
                CFO_IDX_CFG_MID: begin
                    en_mid <= shift;
                end
                CFO_IDX_CFG_HIGH: begin
                    en_high <= shift[CFO_HIGH_MSB:CFO_HIGH_LSB];
                end
                default: begin
                    // Address, command and count bytes change nothing
                    en_low <= en_low;
                end
            endcase
        end
    end

    assign en_all = {en_high, en_mid, en_low};

    // Outputs follow the synchronised buffer input, so they lag it by a few clocks
    // and cannot pass edges faster than half the system clock rate
    genvar gi;
    generate
        for (gi = 0; gi < CFO_NUM_OUTPUTS; gi++) begin : g_out
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    o_clk_out[gi] <= 1'b0;
                    o_clk_oe[gi] <= 1'b1;
                end else begin
                    o_clk_out[gi] <= float_s2 && en_all[gi] && buf_s2;
                    o_clk_oe[gi] <= float_s2;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_enables <= {CFO_RST_EN_HIGH, CFO_RST_EN_MID, CFO_RST_EN_LOW};
        end else begin
            o_enables <= en_all;
        end
    end

endmodule

`default_nettype wire

/* rtl/cfo_host.sv */
`timescale 1ns/1ps
`default_nettype none

module cfo_host
    import cfo_pkg::*;
#(
    parameter int QTR_CYC = CFO_QTR_CYC
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    cfo_if.host bus,
    input wire logic i_go,
    input wire logic [7:0] i_addr_byte,
    input wire logic [7:0] i_cmd_byte,
    input wire logic [7:0] i_count_byte,
    input wire logic [7:0] i_cfg_low,
    input wire logic [7:0] i_cfg_mid,
    input wire logic [7:0] i_cfg_high,
    input wire logic [1:0] i_cfg_num,
    output logic o_busy,
    output logic o_done,
    output logic o_nack
);

    cfo_host_state_t state;
    logic [15:0] qtr_cnt;
    logic tick;
    logic [1:0] quarter;
    logic [3:0] bit_cnt;
    logic [2:0] byte_idx;
    logic [2:0] last_idx;
    logic [7:0] bytes [0:5];
    logic [7:0] cur_byte;
    logic scl_lvl;
    logic sda_lvl;
    logic sda_s1;
    logic sda_s2;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
        end
    end

    assign tick = (qtr_cnt == 16'(QTR_CYC - 1));

    always_ff @(posedge i_clk) begin
        if (i_rst || state == CFO_HOST_IDLE || tick) begin
            qtr_cnt <= 16'h0000;
        end else begin
            qtr_cnt <= qtr_cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || state == CFO_HOST_IDLE) begin
            quarter <= 2'h0;
        end else if (tick) begin
            quarter <= quarter + 2'h1;
        end
    end

    assign cur_byte = bytes[byte_idx];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 6; k++) begin
                bytes[k] <= 8'h00;
            end
            last_idx <= CFO_IDX_COUNT;
        end else if (state == CFO_HOST_IDLE && i_go) begin
            bytes[0] <= i_addr_byte;
            bytes[1] <= i_cmd_byte;
            bytes[2] <= i_count_byte;
            bytes[3] <= i_cfg_low;
            bytes[4] <= i_cfg_mid;
            bytes[5] <= i_cfg_high;
            // Each enable byte can only be reached by sending the ones before it
            last_idx <= CFO_IDX_COUNT + {1'b0, i_cfg_num};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= CFO_HOST_IDLE;
            scl_lvl <= 1'b1;
            sda_lvl <= 1'b1;
            bit_cnt <= 4'h0;
            byte_idx <= CFO_IDX_ADDR;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_nack <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state)
                CFO_HOST_IDLE: begin
                    if (i_go) begin
                        state <= CFO_HOST_START;
                        o_busy <= 1'b1;
                        o_nack <= 1'b0;
                        bit_cnt <= 4'h0;
                        byte_idx <= CFO_IDX_ADDR;
                    end
                end
                CFO_HOST_START: begin
                    if (tick && quarter == 2'h1) begin
                        sda_lvl <= 1'b0;
                    end else if (tick && quarter == 2'h3) begin
                        scl_lvl <= 1'b0;
                        state <= CFO_HOST_BIT;
                    end
                end
                CFO_HOST_BIT: begin
                    if (tick && quarter == 2'h0) begin
                        // Data moves one quarter into the clock low time
                        if (bit_cnt == CFO_BITS_PER_BYTE) begin
                            sda_lvl <= 1'b1;
                        end else begin
                            sda_lvl <= cur_byte[3'(7 - bit_cnt)];
                        end
                    end else if (tick && quarter == 2'h1) begin
                        scl_lvl <= 1'b1;
                    end else if (tick && quarter == 2'h3) begin
                        scl_lvl <= 1'b0;
                        if (bit_cnt != CFO_BITS_PER_BYTE) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (sda_s2 || byte_idx == last_idx) begin
                            o_nack <= sda_s2;
                            state <= CFO_HOST_STOP;
                        end else begin
                            bit_cnt <= 4'h0;
                            byte_idx <= byte_idx + 3'h1;
                        end
                    end
                end
                CFO_HOST_STOP: begin
                    if (tick && quarter == 2'h0) begin
                        sda_lvl <= 1'b0;
                    end else if (tick && quarter == 2'h1) begin
                        scl_lvl <= 1'b1;
                    end else if (tick && quarter == 2'h2) begin
                        sda_lvl <= 1'b1;
                    end else if (tick && quarter == 2'h3) begin
                        state <= CFO_HOST_IDLE;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Open-drain: a high level is produced by releasing the line
    assign bus.scl_host_o = 1'b0;
    assign bus.scl_host_oe = !scl_lvl;
    assign bus.sda_host_o = 1'b0;
    assign bus.sda_host_oe = !sda_lvl;

endmodule

`default_nettype wire

/* verification/cfo_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module cfo_sva
    import cfo_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe,
    input wire logic i_buf_in,
    input wire logic i_float_n,
    input wire logic [CFO_NUM_OUTPUTS-1:0] o_clk_out,
    input wire logic [CFO_NUM_OUTPUTS-1:0] o_clk_oe,
    input wire logic [CFO_NUM_OUTPUTS-1:0] o_enables
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Raw lines are watched, so the slot count leads the device's synced view by a few clocks
    logic scl_q;
    logic sda_q;
    logic first;
    logic [3:0] cnt;
    logic [7:0] sh;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first <= 1'b0;
            cnt <= 4'h0;
            sh <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) begin
                cnt <= 4'h0;
                first <= 1'b1;
            end else if (scl && !scl_q) begin
                cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
                sh <= {sh[6:0], sda};
                if (cnt == 4'h8) begin
                    first <= 1'b0;
                end
            end
        end
    end

    a_ack_slot_only: assert property (($rose(scl) && sda_dev_oe) |-> cnt == 4'h8)
        else $error("device pulls data outside the acknowledge slot");
    a_addr_match: assert property (($rose(scl) && cnt == 4'h8 && first) |-> sda_dev_oe == (sh == CFO_DEV_ADDR_BYTE))
        else $error("address acknowledge does not match the address byte");
    a_ack_hold: assert property (($rose(scl) && sda_dev_oe) |-> sda_dev_oe [*4])
        else $error("acknowledge dropped during the ninth clock");
    a_sda_change_low: assert property (($rose(sda_dev_oe) || $fell(sda_dev_oe)) |-> !scl)
        else $error("device changed data while clock high");
    a_float_off: assert property (!i_float_n [*5] |-> (o_clk_oe == '0 && o_clk_out == '0))
        else $error("outputs still driven while float pin low");
    a_float_drive: assert property (i_float_n [*5] |-> o_clk_oe == '1)
        else $error("outputs not driven while float pin high");
    a_disabled_low: assert property ((~o_enables & ~$past(o_enables) & o_clk_out) == '0)
        else $error("disabled output not held low");
    a_out_follow: assert property (($stable(i_buf_in) && i_float_n && $stable(o_enables)) [*5]
        |-> o_clk_out == ({CFO_NUM_OUTPUTS{i_buf_in}} & o_enables))
        else $error("enabled output does not copy buffer input");
    // The clock rises again right after the release, so the release itself is what is timed
    a_apply_after_ack: assert property ($changed(o_enables) |-> (!sda_dev_oe && $past(sda_dev_oe, 2)))
        else $error("enables changed before the acknowledge ended");
endmodule

`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import cfo_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0;
    logic buf_in = 1'b0;
    logic float_n = 1'b1;
    logic [2:0] bcnt = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] cmd = 8'h00;
    logic [7:0] cnt_b = 8'h00;
    logic [7:0] lo = 8'h00;
    logic [7:0] mid = 8'h00;
    logic [7:0] hi = 8'h00;
    logic [1:0] num = 2'h0;
    logic [17:0] clk_out;
    logic [17:0] clk_oe;
    logic [17:0] enables;
    logic [17:0] exp_en;
    logic busy;
    logic done;
    logic nack;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    always #10 i_clk = ~i_clk;

    // Buffer input held 8 clocks per level so the output pipeline settles between edges
    always @(posedge i_clk) begin
        bcnt <= bcnt + 3'h1;
        if (bcnt == 3'h7) begin
            buf_in <= ~buf_in;
        end
    end

    cfo_if i_cfo_if ();

    cfo_device i_cfo_device (.i_clk(i_clk), .i_rst(i_rst), .bus(i_cfo_if), .i_buf_in(buf_in),
        .i_float_n(float_n), .o_clk_out(clk_out), .o_clk_oe(clk_oe), .o_enables(enables));

    cfo_host i_cfo_host (.i_clk(i_clk), .i_rst(i_rst), .bus(i_cfo_if), .i_go(go), .i_addr_byte(addr),
        .i_cmd_byte(cmd), .i_count_byte(cnt_b), .i_cfg_low(lo), .i_cfg_mid(mid), .i_cfg_high(hi),
        .i_cfg_num(num), .o_busy(busy), .o_done(done), .o_nack(nack));

    cfo_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .scl(i_cfo_if.scl), .sda(i_cfo_if.sda),
        .sda_dev_oe(i_cfo_if.sda_dev_oe), .i_buf_in(buf_in), .i_float_n(float_n),
        .o_clk_out(clk_out), .o_clk_oe(clk_oe), .o_enables(enables));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Command and count bytes vary with the data so their contents are shown to be ignored
    task automatic wr(input logic [7:0] a, input logic [7:0] l, input logic [7:0] m, input logic [7:0] h,
        input logic [1:0] n);
        int k;
        @(posedge i_clk);
        addr <= a;
        cmd <= a ^ l;
        cnt_b <= ~l;
        lo <= l;
        mid <= m;
        hi <= h;
        num <= n;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        @(negedge i_clk);
        check("busy", {17'h0, busy}, 18'h1);
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge i_clk);
        check("done", {17'h0, k < 3000}, 18'h1);
        check("idle", {17'h0, busy}, 18'h0);
        repeat (8) @(negedge i_clk);
    endtask

    task automatic watch_low(input int n);
        repeat (n) begin
            @(negedge i_clk);
            check("disabled_low", clk_out & ~exp_en, 18'h0);
        end
    endtask

    task automatic t_float();
        @(posedge i_clk);
        float_n <= 1'b0;
        repeat (8) @(negedge i_clk);
        check("oe_float", clk_oe, 18'h0);
        check("out_float", clk_out, 18'h0);
        @(posedge i_clk);
        float_n <= 1'b1;
        repeat (8) @(negedge i_clk);
        check("oe_drive", clk_oe, 18'h3FFFF);
        $display("t_float done");
    endtask

    task automatic t_full();
        wr(8'hD2, 8'h5A, 8'hC3, 8'h7F, 2'h3);
        exp_en = {2'b01, 8'hC3, 8'h5A};
        check("nack", {17'h0, nack}, 18'h0);
        check("enables", enables, exp_en);
        watch_low(24);
        wr(8'hD2, 8'hA5, 8'h3C, 8'hBF, 2'h3);
        exp_en = {2'b10, 8'h3C, 8'hA5};
        check("enables", enables, exp_en);
        $display("t_full done");
    endtask

    task automatic t_partial();
        int n;
        for (n = 0; n < 4; n++) begin
            // The last pass writes a high byte that differs from the one already held
            wr(8'hD2, 8'h30 | 8'(n), 8'h0C | 8'(n), n[0] ? 8'h40 : 8'h80, 2'(n));
            if (n >= 1) exp_en[7:0] = 8'h30 | 8'(n);
            if (n >= 2) exp_en[15:8] = 8'h0C | 8'(n);
            if (n >= 3) exp_en[17:16] = n[0] ? 2'b01 : 2'b10;
            check("partial", enables, exp_en);
        end
        $display("t_partial done");
    endtask

    task automatic t_bad_addr();
        logic [7:0] bad [3];
        int i;
        bad = '{8'hD3, 8'hD0, 8'h52};
        for (i = 0; i < 3; i++) begin
            wr(bad[i], 8'h00, 8'h00, 8'h00, 2'h3);
            check("nack_bad", {17'h0, nack}, 18'h1);
            check("kept", enables, exp_en);
        end
        $display("t_bad_addr done");
    endtask

    task automatic t_all_off();
        wr(8'hD2, 8'h00, 8'h00, 8'h00, 2'h3);
        exp_en = 18'h0;
        check("all_off", enables, exp_en);
        watch_low(20);
        $display("t_all_off done");
    endtask

    task automatic t_reset();
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (6) @(negedge i_clk);
        exp_en = 18'h3FFFF;
        check("enables_rst", enables, exp_en);
        check("oe_rst", clk_oe, 18'h3FFFF);
        $display("t_reset done");
    endtask

    initial begin
        exp_en = 18'h3FFFF;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (6) @(negedge i_clk);
        check("enables_pwr", enables, exp_en);
        t_float();
        t_full();
        t_partial();
        t_bad_addr();
        t_all_off();
        t_reset();
        print_verdict();
    end
endmodule

`default_nettype wire
